// >>> core/tmc_channel.sv
// One 8-bit timer/counter channel: timer, event counter, divider output
// and PWM modes, with an APB register slave.
// Assumes clock ticks and the event pin are synchronous to pclk.
//
// Functional notes
// [RQ1] Timer counts clock, match irqs and clears
// [RQ2] Compare write acts at once, unbuffered
// [RQ3] Software keeps preset bit zero in timer
// [RQ4] Event mode counts falling edges of pin
// [RQ5] Event pin levels last two cycles minimum
// [RQ6] Divider mode toggles flop on each match
// [RQ7] Divider pin is inverse flop, resets zero
// [RQ8] Software sets port latch before output
// [RQ9] Stopping holds pin; preset in later write
// [RQ10] Control bit 3 starts and stops counter
// [RQ11] Preset bit cleared while stopped clears flop
// [RQ12] Control codes select clock and mode
// [RQ13] PWM toggles on duty match and overflow
// [RQ14] PWM pin is inverse flop, resets zero
// [RQ15] Duty double-buffered, loads at interrupt
// [RQ16] Duty reads show active stage value
// [RQ17] Software writes duty right after interrupt
// [RQ18] Software stops channel before stop mode
// [RQ19] Four prescaled clocks, low-speed alternative
// [RQ20] PWM adds low, half and full clocks
// [RQ21] Software keeps compare and duty in range
// [RQ22] Counter eight bits, cleared while stopped
//
// Decided for this implementation: the APB interface to the registers and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none

module tmc_channel
  import tmc_pkg::*;
#(
  parameter int CNT_W = 8
) (
  input wire logic pclk, // Bus clock, 200 MHz
  input wire logic presetn, // Async reset, active low
  input wire logic ce, // Clock enable, freezes all state when low
  input wire logic psel, // APB select
  input wire logic penable, // APB access phase
  input wire logic pwrite, // APB direction, high for write
  input wire logic [7:0] paddr, // APB byte address
  input wire logic [31:0] pwdata, // APB write data
  output logic [31:0] prdata, // APB read data
  output logic pready, // APB ready
  output logic pslverr, // APB error on unmapped address
  input wire logic high_speed_clk, // High-speed clock tick
  input wire logic low_speed_clk, // Low-speed clock tick
  input wire logic slow_mode, // Slow or sleep operation
  input wire logic event_in_pin, // External event input
  output logic channel_irq, // Interrupt request pulse
  output logic divider_out_pin, // Divider output, inverse flop
  output logic pwm_out_pin // PWM output, inverse flop
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  logic [7:0] ctrl_reg, ctrl_next;
  logic [CNT_W-1:0] cmp_reg, cmp_next;
  logic [CNT_W-1:0] duty_buf_reg, duty_buf_next;
  logic [CNT_W-1:0] duty_act_reg, duty_act_next;
  logic [CNT_W-1:0] cnt_reg, cnt_next;
  logic presel_reg, presel_next;
  logic ff_reg, ff_next;
  logic irq_reg, irq_next;
  logic div_pin_reg, pwm_pin_reg;
  logic [31:0] prdata_reg, prdata_next;
  logic pready_reg, pready_next;
  logic pslverr_reg, pslverr_next;

  // ----------------------------------------------------------------
  // APB decode
  // ----------------------------------------------------------------
  // Setup registers the read data, so access completes one cycle later
  wire setup_ph = psel & ~penable;
  wire access_done = psel & penable & pready_reg;
  wire wr_done = access_done & pwrite;
  wire hit_ctrl = (paddr == TMC_OFS_CTRL);
  wire hit_cmp = (paddr == TMC_OFS_CMP);
  wire hit_duty = (paddr == TMC_OFS_DUTY);
  wire hit_cfg = (paddr == TMC_OFS_CFG);
  wire hit_stat = (paddr == TMC_OFS_STAT);
  wire hit_any = hit_ctrl | hit_cmp | hit_duty | hit_cfg | hit_stat;
  wire wr_ctrl = wr_done & hit_ctrl;
  wire wr_cmp = wr_done & hit_cmp;
  wire wr_duty = wr_done & hit_duty;
  wire wr_cfg = wr_done & hit_cfg;

  // ----------------------------------------------------------------
  // Control fields
  // ----------------------------------------------------------------
  wire running = ctrl_reg[TMC_CTRL_START_BIT];
  wire [2:0] mode = ctrl_reg[TMC_CTRL_MODE_LSB +: 3];
  wire [2:0] ck_sel = ctrl_reg[TMC_CTRL_CK_LSB +: 3];
  wire mode_pwm = (mode == TMC_MODE_PWM);
  wire mode_pdo = (mode == TMC_MODE_PDO);
  wire mode_cmp = (mode == TMC_MODE_TIMER) | mode_pdo;
  wire new_start = pwdata[TMC_CTRL_START_BIT];

  // ----------------------------------------------------------------
  // Source clock selection
  // ----------------------------------------------------------------
  logic [TMC_TAP_SLOWEST:0] hs_div;
  logic [TMC_TAP_LOW8:0] ls_div;
  logic ev_fall;

  tmc_prescaler #(
    .HS_W(TMC_TAP_SLOWEST),
    .LS_W(TMC_TAP_LOW8)
  ) u_pre (
    .pclk(pclk),
    .presetn(presetn),
    .ce(ce),
    .hs_tick(high_speed_clk),
    .ls_tick(low_speed_clk),
    .hs_div(hs_div),
    .ls_div(ls_div)
  );

  tmc_fall_detect u_fall (
    .pclk(pclk),
    .presetn(presetn),
    .ce(ce),
    .level(event_in_pin),
    .fall(ev_fall)
  );

  // [RQ19] prescaled internal clocks
  // Slow operation blocks the high-speed taps and moves the slowest code to the low-speed divide-by-8 path
  wire use_low8 = presel_reg | slow_mode;
  wire tick_slowest = use_low8 ? ls_div[TMC_TAP_LOW8] : hs_div[TMC_TAP_SLOWEST];
  wire tick_hs_ok = ~slow_mode;
  // [RQ20] extra PWM clocks
  // Low, half and full clocks are valid in PWM only; elsewhere no tick
  wire tick_low = mode_pwm & ls_div[0];
  wire tick_half = mode_pwm & tick_hs_ok & hs_div[TMC_TAP_HALF];
  wire tick_full = mode_pwm & tick_hs_ok & hs_div[0];
  // [RQ4] external edge as count source
  // The pin source only counts in timer mode, the event counter
  wire tick_pin = (mode == TMC_MODE_TIMER) & ev_fall;
  // [RQ12] clock code decode
  wire tick =
    (ck_sel == TMC_CK_SLOWEST) ? tick_slowest :
    (ck_sel == TMC_CK_DIV128) ? tick_hs_ok & hs_div[TMC_TAP_DIV128] :
    (ck_sel == TMC_CK_DIV32) ? tick_hs_ok & hs_div[TMC_TAP_DIV32] :
    (ck_sel == TMC_CK_DIV8) ? tick_hs_ok & hs_div[TMC_TAP_DIV8] :
    (ck_sel == TMC_CK_LOW) ? tick_low :
    (ck_sel == TMC_CK_HALF) ? tick_half :
    (ck_sel == TMC_CK_FULL) ? tick_full :
    tick_pin;

  // ----------------------------------------------------------------
  // Counter events
  // ----------------------------------------------------------------
  wire run_tick = running & tick;
  wire [CNT_W-1:0] cnt_inc = CNT_W'(cnt_reg + 1'b1);
  // [RQ1] compare match
  // Match is taken on the incremented value, so the period is cmp ticks
  wire cmp_match = run_tick & mode_cmp & (cnt_inc == cmp_reg);
  // [RQ22] wrap at full count
  wire pwm_ovf = run_tick & mode_pwm & (&cnt_reg);
  wire pwm_match = run_tick & mode_pwm & ~(&cnt_reg) & (cnt_inc == duty_act_reg);
  wire stop_wr = wr_ctrl & running & ~new_start;

  // [RQ22] counter held clear while stopped
  always_comb begin
    if (!running) cnt_next = '0;
    else if (cmp_match | pwm_ovf) cnt_next = '0;
    else if (run_tick & (mode_cmp | mode_pwm)) cnt_next = cnt_inc;
    else cnt_next = cnt_reg;
  end

  // [RQ6] [RQ13] flop toggles on match or overflow
  // [RQ9] [RQ11] preset only while stopped; a stopping write holds the flop
  always_comb begin
    if ((cmp_match & mode_pdo) | pwm_match | pwm_ovf) ff_next = ~ff_reg;
    else if (wr_ctrl & !running) ff_next = pwdata[TMC_CTRL_FF_BIT];
    else ff_next = ff_reg;
  end

  // [RQ1] [RQ6] [RQ13] interrupt pulse
  assign irq_next = cmp_match | pwm_ovf;

  // [RQ10] control and start bit
  assign ctrl_next = wr_ctrl ? pwdata[7:0] : ctrl_reg;
  // [RQ2] compare written straight through
  assign cmp_next = wr_cmp ? pwdata[CNT_W-1:0] : cmp_reg;
  assign presel_next = wr_cfg ? pwdata[TMC_CFG_PRESEL_BIT] : presel_reg;
  assign duty_buf_next = wr_duty ? pwdata[CNT_W-1:0] : duty_buf_reg;

  // [RQ15] duty transfer
  // A write in the overflow cycle misses this transfer and waits a period
  always_comb begin
    if (!running) duty_act_next = wr_duty ? pwdata[CNT_W-1:0] : duty_buf_reg;
    else if (pwm_ovf) duty_act_next = duty_buf_reg;
    else duty_act_next = duty_act_reg;
  end

  // ----------------------------------------------------------------
  // Read data and handshake
  // ----------------------------------------------------------------
  // [RQ16] duty reads return active stage
  wire [31:0] stat_word = {16'h0000, cnt_reg, 6'h00, ff_reg, running};
  wire [31:0] rd_word =
    hit_ctrl ? {24'h000000, ctrl_reg} :
    hit_cmp ? {24'h000000, cmp_reg} :
    hit_duty ? {24'h000000, duty_act_reg} :
    hit_cfg ? {31'h00000000, presel_reg} :
    hit_stat ? stat_word :
    32'h00000000;
  assign prdata_next = (setup_ph & ~pwrite) ? rd_word : prdata_reg;
  assign pready_next = setup_ph ? 1'b1 : (access_done ? 1'b0 : pready_reg);
  assign pslverr_next = setup_ph ? ~hit_any : (access_done ? 1'b0 : pslverr_reg);

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  // Bus-facing flops
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_reg <= 32'h00000000;
      pready_reg <= 1'b0;
      pslverr_reg <= 1'b0;
    end else if (ce) begin
      prdata_reg <= prdata_next;
      pready_reg <= pready_next;
      pslverr_reg <= pslverr_next;
    end
  end

  // Software-written registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_reg <= TMC_CTRL_RST;
      cmp_reg <= TMC_CMP_RST;
      duty_buf_reg <= TMC_DUTY_RST;
      presel_reg <= TMC_CFG_RST;
    end else if (ce) begin
      ctrl_reg <= ctrl_next;
      cmp_reg <= cmp_next;
      duty_buf_reg <= duty_buf_next;
      presel_reg <= presel_next;
    end
  end

  // [RQ7] [RQ14] pins are inverse of flop, flop resets clear
  // Pins are registered from ff_next so they track the flop exactly
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_reg <= '0;
      duty_act_reg <= TMC_DUTY_RST;
      ff_reg <= TMC_FF_RST;
      irq_reg <= 1'b0;
      div_pin_reg <= ~TMC_FF_RST;
      pwm_pin_reg <= ~TMC_FF_RST;
    end else if (ce) begin
      cnt_reg <= cnt_next;
      duty_act_reg <= duty_act_next;
      ff_reg <= ff_next;
      irq_reg <= irq_next;
      div_pin_reg <= ~ff_next;
      pwm_pin_reg <= ~ff_next;
    end
  end

  assign prdata = prdata_reg;
  assign pready = pready_reg;
  assign pslverr = pslverr_reg;
  assign channel_irq = irq_reg;
  assign divider_out_pin = div_pin_reg;
  assign pwm_out_pin = pwm_pin_reg;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  // [RQ1] match clears and interrupts
  a_match_clear_irq: assert property ( // [RQ1]
    ce & cmp_match |=> irq_reg && cnt_reg == '0)
    else $error("compare match did not clear counter and interrupt");

  // [RQ4] pin edge advances count
  a_event_count: assert property ( // [RQ4]
    ce & running & mode == TMC_MODE_TIMER & ck_sel == TMC_CK_PIN & ev_fall & !cmp_match
    |=> cnt_reg == CNT_W'($past(cnt_reg) + 1'b1))
    else $error("event edge did not advance counter");

  // [RQ6] divider toggles at match
  a_pdo_toggle: assert property ( // [RQ6]
    ce & cmp_match & mode_pdo |=> ff_reg != $past(ff_reg) && divider_out_pin == !ff_reg)
    else $error("divider flop did not toggle on match");

  // [RQ7] [RQ14] pins follow inverse flop
  a_pin_inverse: assert property ( // [RQ7]
    divider_out_pin == !ff_reg && pwm_out_pin == !ff_reg)
    else $error("output pin is not inverse of flop");

  // [RQ9] stop write holds pin
  a_stop_hold_pin: assert property ( // [RQ9]
    ce & stop_wr |=> $stable(divider_out_pin) ##1 (!running))
    else $error("pin changed on the stopping write");

  // [RQ10] start bit follows write
  a_start_bit: assert property ( // [RQ10]
    ce & wr_ctrl |=> running == $past(pwdata[TMC_CTRL_START_BIT]))
    else $error("start bit did not follow write");

  // [RQ11] preset while stopped
  a_stopped_preset: assert property ( // [RQ11]
    ce & wr_ctrl & !running |=> ff_reg == $past(pwdata[TMC_CTRL_FF_BIT]))
    else $error("flop not preset by stopped write");

  // [RQ13] overflow wraps, toggles, interrupts
  a_pwm_overflow: assert property ( // [RQ13]
    ce & pwm_ovf |=> irq_reg && cnt_reg == '0 && ff_reg != $past(ff_reg))
    else $error("pwm overflow misbehaved");

  // [RQ15] duty transfers at overflow
  a_duty_transfer: assert property ( // [RQ15]
    ce & pwm_ovf |=> duty_act_reg == $past(duty_buf_reg))
    else $error("duty buffer not transferred at overflow");

  // [RQ16] read returns active duty
  a_duty_read: assert property ( // [RQ16]
    ce & setup_ph & !pwrite & hit_duty |=> prdata[CNT_W-1:0] == $past(duty_act_reg))
    else $error("duty read did not return active stage");

  // [RQ22] stopped counter stays clear
  a_stop_clear_cnt: assert property ( // [RQ22]
    (!running ##1 !running) |-> cnt_reg == '0)
    else $error("counter not clear while stopped");

  c_timer_match: cover property (running & mode == TMC_MODE_TIMER & cmp_match);
  c_pdo_toggle: cover property (running & mode_pdo & cmp_match ##[1:300] cmp_match);
  c_pwm_cycle: cover property (pwm_match ##[1:300] pwm_ovf);
  c_event_edge: cover property (running & ck_sel == TMC_CK_PIN & ev_fall);

endmodule

`default_nettype wire

// >>> core/tmc_fall_detect.sv
// Falling-edge detector for the external event input.
// Assumes the input is synchronous to pclk and holds each level >= 2 cycles.
`timescale 1ns/1ps
`default_nettype none

module tmc_fall_detect (
  input wire logic pclk, // Bus clock
  input wire logic presetn, // Async reset, active low
  input wire logic ce, // Clock enable
  input wire logic level, // Sampled input level
  output logic fall // One cycle on a high-to-low step
);

  logic prev_reg;

  // Reset high, so a pin held low at start is seen as an edge in the first cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) prev_reg <= 1'b1;
    else if (ce) prev_reg <= level;
  end

  assign fall = prev_reg & ~level;

endmodule

`default_nettype wire

// >>> core/tmc_prescaler.sv
// Free-running prescaler for the high-speed and low-speed tick inputs.
// Assumes both ticks are one-cycle enables synchronous to pclk.
`timescale 1ns/1ps
`default_nettype none

module tmc_prescaler #(
  parameter int HS_W = 11,
  parameter int LS_W = 3
) (
  input wire logic pclk, // Bus clock
  input wire logic presetn, // Async reset, active low
  input wire logic ce, // Clock enable
  input wire logic hs_tick, // High-speed clock tick
  input wire logic ls_tick, // Low-speed clock tick
  output logic [HS_W:0] hs_div, // Bit k ticks every 2^k high ticks
  output logic [LS_W:0] ls_div // Bit k ticks every 2^k low ticks
);

  logic [HS_W-1:0] hs_cnt_reg;
  logic [LS_W-1:0] ls_cnt_reg;

  // Counters run always, so a tap phase is unrelated to channel start
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      hs_cnt_reg <= '0;
      ls_cnt_reg <= '0;
    end else if (ce) begin
      if (hs_tick) hs_cnt_reg <= hs_cnt_reg + 1'b1;
      if (ls_tick) ls_cnt_reg <= ls_cnt_reg + 1'b1;
    end
  end

  // A tap fires when all lower counter bits are one on a tick
  assign hs_div[0] = hs_tick;
  assign ls_div[0] = ls_tick;
  for (genvar k = 1; k <= HS_W; k++) begin : g_hs
    assign hs_div[k] = hs_tick & (&hs_cnt_reg[k-1:0]);
  end
  for (genvar k = 1; k <= LS_W; k++) begin : g_ls
    assign ls_div[k] = ls_tick & (&ls_cnt_reg[k-1:0]);
  end

endmodule

`default_nettype wire

// >>> inc/tmc_pkg.sv
// Shared constants of the 8-bit timer/counter channel: register map,
// control field layout, reset values, clock-select and mode codes.
// Assumes a 32-bit APB slave with byte addresses on word boundaries.

package tmc_pkg;

  // ----------------------------------------------------------------
  // Register map (byte addresses)
  // ----------------------------------------------------------------
  localparam logic [7:0] TMC_OFS_CTRL = 8'h00;
  localparam logic [7:0] TMC_OFS_CMP = 8'h04;
  localparam logic [7:0] TMC_OFS_DUTY = 8'h08;
  localparam logic [7:0] TMC_OFS_CFG = 8'h0c;
  localparam logic [7:0] TMC_OFS_STAT = 8'h10;

  // ----------------------------------------------------------------
  // Control and config register fields
  // ----------------------------------------------------------------
  localparam int TMC_CTRL_FF_BIT = 7;
  localparam int TMC_CTRL_CK_LSB = 4;
  localparam int TMC_CTRL_START_BIT = 3;
  localparam int TMC_CTRL_MODE_LSB = 0;
  localparam int TMC_CFG_PRESEL_BIT = 0;

  // Status register fields
  localparam int TMC_STAT_RUN_BIT = 0;
  localparam int TMC_STAT_FF_BIT = 1;
  localparam int TMC_STAT_CNT_LSB = 8;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [7:0] TMC_CTRL_RST = 8'h00;
  localparam logic [7:0] TMC_CMP_RST = 8'h00;
  localparam logic [7:0] TMC_DUTY_RST = 8'h00;
  localparam logic TMC_CFG_RST = 1'b0;
  localparam logic TMC_FF_RST = 1'b0;

  // ----------------------------------------------------------------
  // Clock select codes (control bits 6:4)
  // ----------------------------------------------------------------
  localparam logic [2:0] TMC_CK_SLOWEST = 3'h0;
  localparam logic [2:0] TMC_CK_DIV128 = 3'h1;
  localparam logic [2:0] TMC_CK_DIV32 = 3'h2;
  localparam logic [2:0] TMC_CK_DIV8 = 3'h3;
  localparam logic [2:0] TMC_CK_LOW = 3'h4;
  localparam logic [2:0] TMC_CK_HALF = 3'h5;
  localparam logic [2:0] TMC_CK_FULL = 3'h6;
  localparam logic [2:0] TMC_CK_PIN = 3'h7;

  // Prescaler taps, as powers of two
  localparam int TMC_TAP_SLOWEST = 11;
  localparam int TMC_TAP_DIV128 = 7;
  localparam int TMC_TAP_DIV32 = 5;
  localparam int TMC_TAP_DIV8 = 3;
  localparam int TMC_TAP_HALF = 1;
  localparam int TMC_TAP_LOW8 = 3;

  // ----------------------------------------------------------------
  // Mode codes (control bits 2:0)
  // ----------------------------------------------------------------
  localparam logic [2:0] TMC_MODE_TIMER = 3'h0;
  localparam logic [2:0] TMC_MODE_PDO = 3'h1;
  localparam logic [2:0] TMC_MODE_PWM = 3'h2;

endpackage

// >>> testbench/tmc_channel_tb.sv
// Self-checking bench of the timer channel, driven through its APB slave.
// Assumes tmc_pkg, the design files and the far-side model come first.
`timescale 1ns/1ps
`default_nettype none

`define CHK(nm, ex, got) begin compares++; if ((got) !== (ex)) begin bad_count++; \
  $display("[FAIL] %s expected %0h got %0h", nm, ex, got); end end

module tmc_channel_tb
  import tmc_pkg::*;
;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, q;
  logic pready, pslverr, err, channel_irq, divider_out_pin, pwm_out_pin, event_in_pin;
  logic ls_tick = 1'b0, slow_mode = 1'b0, go = 1'b0, busy, pdo_pad, pwm_pad, p;
  logic [7:0] pulses = 8'h01;
  logic [1:0] ls_cnt = 2'h0;
  int bad_count = 0, compares = 0, n = 0, irq_total = 0, base = 0;
  int ck_per[6] = '{2048, 128, 32, 8, 32, 32};
  logic [2:0] ck_code[6] = '{3'h0, 3'h1, 3'h2, 3'h3, 3'h0, 3'h0};
  logic ck_cfg[6] = '{1'b0, 1'b0, 1'b0, 1'b0, 1'b1, 1'b0};
  logic ck_slow[6] = '{1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 1'b1};

  // ----------------------------------------------------------------
  // Clock, ticks and instances
  // ----------------------------------------------------------------
  initial begin
    forever #2.5 pclk = ~pclk;
  end

  // Low-speed tick every fourth cycle so its taps differ from the fast ones
  always @(posedge pclk) begin
    ls_cnt <= ls_cnt + 2'h1;
    ls_tick <= (ls_cnt == 2'h3);
  end

  // Interrupt pulses counted on the settled half of the cycle
  always @(negedge pclk) begin
    if (channel_irq === 1'b1) begin
      irq_total <= irq_total + 1;
    end
  end

  tmc_channel uut (.pclk(pclk), .presetn(presetn), .ce(1'b1), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .high_speed_clk(1'b1),
    .low_speed_clk(ls_tick), .slow_mode(slow_mode), .event_in_pin(event_in_pin),
    .channel_irq(channel_irq), .divider_out_pin(divider_out_pin),
    .pwm_out_pin(pwm_out_pin));

  tmc_far_side #(.HALF(3)) far (.pclk(pclk), .presetn(presetn), .go(go),
    .pulses(pulses), .port_latch(1'b1), .divider_out_pin(divider_out_pin),
    .pwm_out_pin(pwm_out_pin), .event_in_pin(event_in_pin), .busy(busy),
    .pdo_pad(pdo_pad), .pwm_pad(pwm_pad));

  // ----------------------------------------------------------------
  // Bus and wait tasks
  // ----------------------------------------------------------------
  task automatic results();
    $display("Comparisons %0d, mismatches %0d", compares, bad_count);
    if (bad_count == 0 && compares > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  task automatic hang();
    bad_count++;
    $display("[FAIL] wait expected done got timeout");
    results();
  endtask

  // One APB transfer; request held until pready is sampled high
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int k;
    k = 0;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // Registered answer is settled on the falling edge before the access edge
    do begin
      @(negedge pclk);
      k++;
    end while (pready !== 1'b1 && k < 20);
    if (k >= 20) hang();
    q = prdata;
    err = pslverr;
    @(posedge pclk);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wait_irq();
    n = 0;
    do begin
      @(negedge pclk);
      n++;
    end while (channel_irq !== 1'b1 && n < 5000);
    if (n >= 5000) hang();
  endtask

  task automatic period(input int ex);
    wait_irq();
    wait_irq();
    `CHK("irq period", ex, n)
  endtask

  function automatic logic pad(input logic pw);
    return pw ? pwm_pad : pdo_pad;
  endfunction

  // Length of the next full run of one level on a pad
  task automatic run_len(input logic pw, input logic lvl);
    int k;
    k = 0;
    while (pad(pw) === lvl && k < 3000) begin
      @(negedge pclk);
      k++;
    end
    while (pad(pw) !== lvl && k < 3000) begin
      @(negedge pclk);
      k++;
    end
    n = 0;
    while (pad(pw) === lvl && k < 3000) begin
      @(negedge pclk);
      k++;
      n++;
    end
    if (k >= 3000) hang();
  endtask

  task automatic burst(input logic [7:0] k);
    int w;
    w = 0;
    @(posedge pclk);
    pulses <= k;
    go <= 1'b1;
    @(posedge pclk);
    go <= 1'b0;
    do begin
      @(negedge pclk);
      w++;
    end while (busy === 1'b1 && w < 200);
    if (w >= 200) hang();
  endtask

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    @(negedge pclk);
    `CHK("pdo pin", 1'b1, divider_out_pin)
    `CHK("pwm pin", 1'b1, pwm_out_pin)
    apb(1'b0, TMC_OFS_CTRL, 32'h0);
    `CHK("ctrl reset", 32'h0, q)
    apb(1'b0, 8'h14, 32'h0);
    `CHK("unmapped err", 1'b1, err)
    // Timer period of every internal source with a compare of one
    for (int i = 0; i < 6; i++) begin
      slow_mode <= ck_slow[i];
      apb(1'b1, TMC_OFS_CFG, {31'h0, ck_cfg[i]});
      apb(1'b1, TMC_OFS_CMP, 32'h1);
      apb(1'b1, TMC_OFS_CTRL, {24'h0, 1'b0, ck_code[i], 4'h0});
      apb(1'b1, TMC_OFS_CTRL, {24'h0, 1'b0, ck_code[i], 4'h8});
      period(ck_per[i]);
      apb(1'b1, TMC_OFS_CTRL, 32'h0);
    end
    slow_mode <= 1'b0;
    // Compare writes act at once, not at the next match
    apb(1'b1, TMC_OFS_CMP, 32'h2);
    apb(1'b1, TMC_OFS_CTRL, 32'h38);
    period(16);
    apb(1'b1, TMC_OFS_CMP, 32'hc8);
    wait_irq();
    `CHK("long compare", 1'b1, n > 1000)
    apb(1'b1, TMC_OFS_CMP, 32'h2);
    wait_irq();
    `CHK("short compare", 1'b1, n <= 16)
    apb(1'b1, TMC_OFS_CTRL, 32'h0);
    // Event counting on falling edges of the pin
    apb(1'b1, TMC_OFS_CMP, 32'h3);
    apb(1'b1, TMC_OFS_CTRL, 32'h78);
    base = irq_total;
    burst(8'h02);
    apb(1'b0, TMC_OFS_STAT, 32'h0);
    `CHK("event count", 8'h02, q[15:8])
    `CHK("early irq", base, irq_total)
    burst(8'h01);
    repeat (3) @(negedge pclk);
    `CHK("event irq", base + 1, irq_total)
    apb(1'b0, TMC_OFS_STAT, 32'h0);
    `CHK("event clear", 8'h00, q[15:8])
    apb(1'b1, TMC_OFS_CTRL, 32'h0);
    // Divider output: preset, square wave, hold on stop, clear while stopped
    apb(1'b1, TMC_OFS_CMP, 32'h4);
    apb(1'b1, TMC_OFS_CTRL, 32'hb1);
    @(negedge pclk);
    `CHK("preset pin", 1'b0, pdo_pad)
    apb(1'b1, TMC_OFS_CTRL, 32'hb9);
    run_len(1'b0, 1'b1);
    `CHK("pdo high", 32, n)
    run_len(1'b0, 1'b0);
    `CHK("pdo low", 32, n)
    period(32);
    p = divider_out_pin;
    apb(1'b1, TMC_OFS_CTRL, 32'hb1);
    repeat (40) @(negedge pclk);
    `CHK("pin held", p, divider_out_pin)
    apb(1'b0, TMC_OFS_STAT, 32'h0);
    `CHK("stopped count", 8'h00, q[15:8])
    `CHK("stopped flag", 1'b0, q[0])
    apb(1'b1, TMC_OFS_CTRL, 32'h31);
    @(negedge pclk);
    `CHK("cleared pin", 1'b1, pdo_pad)
    // PWM: buffered duty, widths, overflow period, extra sources
    apb(1'b1, TMC_OFS_CTRL, 32'h62);
    apb(1'b1, TMC_OFS_DUTY, 32'h40);
    apb(1'b0, TMC_OFS_DUTY, 32'h0);
    `CHK("duty stopped", 32'h40, q)
    apb(1'b1, TMC_OFS_CTRL, 32'h6a);
    period(256);
    run_len(1'b1, 1'b0);
    `CHK("pwm low", 192, n)
    wait_irq();
    apb(1'b1, TMC_OFS_DUTY, 32'h80);
    apb(1'b0, TMC_OFS_DUTY, 32'h0);
    `CHK("duty old", 32'h40, q)
    wait_irq();
    apb(1'b0, TMC_OFS_DUTY, 32'h0);
    `CHK("duty new", 32'h80, q)
    run_len(1'b1, 1'b0);
    `CHK("pwm low new", 128, n)
    apb(1'b1, TMC_OFS_CTRL, 32'h62);
    for (int c = 4; c < 6; c++) begin
      apb(1'b1, TMC_OFS_CTRL, {24'h0, 1'b0, 3'(c), 4'h2});
      apb(1'b1, TMC_OFS_CTRL, {24'h0, 1'b0, 3'(c), 4'ha});
      period((c == 4) ? 1024 : 512);
      apb(1'b1, TMC_OFS_CTRL, 32'h0);
    end
    results();
  end
endmodule
`default_nettype wire

// >>> testbench/tmc_far_side.sv
// Far side of the timer channel: an external event source and the port
// pads that load the divider and PWM outputs. Assumes one pclk domain.
`timescale 1ns/1ps
`default_nettype none

module tmc_far_side #(
  parameter int HALF = 3
) (
  input wire logic pclk, // Bus clock
  input wire logic presetn, // Async reset, active low
  input wire logic go, // Start a burst of falling edges
  input wire logic [7:0] pulses, // Falling edges in the burst, not zero
  input wire logic port_latch, // Port output latch of both pads
  input wire logic divider_out_pin, // Channel divider output
  input wire logic pwm_out_pin, // Channel PWM output
  output logic event_in_pin, // Event line into the channel
  output logic busy, // Burst in progress
  output logic pdo_pad, // Level on the divider pad
  output logic pwm_pad // Level on the PWM pad
);
  localparam logic [3:0] HOLD = (HALF < 2) ? 4'h2 : 4'(HALF);
  logic [7:0] left_reg;
  logic [3:0] hold_reg;

  // Latch gates pads
  // A pad shows the timer level only while its port latch is one
  assign pdo_pad = divider_out_pin & port_latch;
  assign pwm_pad = pwm_out_pin & port_latch;
  assign busy = (left_reg != 8'h00);

  // Two-cycle minimum levels
  // Each level lasts HALF cycles, clamped to at least two, so a fast request stays legal
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      left_reg <= 8'h00;
      hold_reg <= 4'h0;
      event_in_pin <= 1'b1;
    end else if (go && !busy) begin
      left_reg <= pulses;
      hold_reg <= HOLD;
      event_in_pin <= 1'b0;
    end else if (busy && hold_reg > 4'h1) begin
      hold_reg <= hold_reg - 4'h1;
    end else if (busy) begin
      hold_reg <= HOLD;
      if (!event_in_pin) begin
        event_in_pin <= 1'b1;
      end else begin
        left_reg <= left_reg - 8'h01;
        event_in_pin <= (left_reg == 8'h01);
      end
    end
  end
endmodule
`default_nettype wire
